/* File: core/omc_pkg.sv */
`default_nettype none

package omc_pkg;

  // ==========================================================
  // Timing and fixed addresses
  localparam logic [3:0]  BIT_LAST     = 4'hF;
  localparam logic [3:0]  BIT_CNT_ZERO = 4'h0;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;

  // ==========================================================
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_RESET = 6'h01,
    MODE_RUN   = 6'h02,
    MODE_HALT  = 6'h04,
    MODE_TRACE = 6'h08,
    MODE_WAIT  = 6'h10,
    MODE_STOP  = 6'h20
  } omc_mode_t;

  // Decoded debug commands from the serial engine
  typedef enum logic [2:0] {
    CMD_MEM      = 3'h0,
    CMD_MEM_STAT = 3'h1,
    CMD_DREG     = 3'h2,
    CMD_HALT     = 3'h3,
    CMD_CPU_REG  = 3'h4,
    CMD_TRACE    = 3'h5,
    CMD_GO       = 3'h6,
    CMD_NONE     = 3'h7
  } omc_cmd_t;

  typedef struct packed {
    logic     valid;
    omc_cmd_t code;
  } omc_cmd_req_t;

  typedef struct packed {
    logic accept;
    logic reject;
    logic lp_error;
  } omc_cmd_rsp_t;

  typedef struct packed {
    logic cpu_run;
    logic cpu_clk;
    logic sys_clk;
    logic core_power;
    logic ram_retain;
  } omc_power_t;

  typedef struct packed {
    omc_mode_t    mode;
    logic         pin_comm;
    logic [3:0]   tick_cnt;
    logic         bit_tick;
    omc_cmd_rsp_t rsp;
    logic         vec_fetch;
    logic         vec_done;
    logic         stop_partial;
    logic         halt_entry;
  } omc_state_t;

  localparam omc_state_t STATE_RESET = '{
    mode: MODE_RESET, pin_comm: 1'b0, tick_cnt: BIT_CNT_ZERO, bit_tick: 1'b0,
    rsp: '{accept: 1'b0, reject: 1'b0, lp_error: 1'b0},
    vec_fetch: 1'b0, vec_done: 1'b0, stop_partial: 1'b0, halt_entry: 1'b0};

endpackage

`default_nettype wire

/* File: core/omc_mode_ctrl.sv */
// Summary of operation
// - pin high at reset release gives run
// - first run entry fetches vector at FFFE
// - pin low at power/forced reset halts
// - halt command enters debug halt
// - halt instruction enters debug halt
// - either breakpoint enters debug halt
// - CPU suspended while halted
// - non-intrusive commands accepted while running
// - non-intrusive commands accepted while halted
// - halt-only commands only while halted
// - go resumes; trace runs one instruction
// - wait gates CPU clock only
// - stop halts all system clocks
// - full stop powered; partial stop retains RAM
// - pin mode-select in reset, debug after
// - debug bit lasts 16 clocks
// - wait accepts halt, status reports error
// - halt command in wait enters halt
`timescale 1ns/1ns
`default_nettype none

module omc_mode_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  sys_reset_act,
  input  wire logic                  reset_mode_sel,
  input  wire logic                  pin_in,
  output logic                       pin_out,
  output logic                       pin_oe,
  output logic                       pin_is_mode_sel,
  input  wire logic                  tx_out,
  input  wire logic                  tx_oe,
  output logic                       bit_tick,
  input  wire omc_pkg::omc_cmd_req_t cmd_req,
  output omc_pkg::omc_cmd_rsp_t      cmd_rsp,
  input  wire logic                  halt_instr,
  input  wire logic                  ctrl_bkpt,
  input  wire logic                  trig_bkpt,
  input  wire logic                  instr_done,
  input  wire logic                  wait_instr,
  input  wire logic                  stop_instr,
  input  wire logic                  stop_partial_sel,
  input  wire logic                  wake_irq,
  output logic                       vec_fetch,
  output logic [15:0]                vec_addr,
  output logic                       halt_entry,
  output omc_pkg::omc_mode_t         mode,
  output omc_pkg::omc_power_t        power
);

  omc_pkg::omc_state_t st;
  omc_pkg::omc_state_t next_st;
  logic                cmd_nonintr;
  logic                cmd_haltonly;
  logic                halt_cmd;
  logic                bkpt_any;
  logic                running;

  // ==========================================================
  // Command classes
  always_comb
  begin
    cmd_nonintr  = cmd_req.valid && (cmd_req.code == omc_pkg::CMD_MEM ||
                   cmd_req.code == omc_pkg::CMD_MEM_STAT ||
                   cmd_req.code == omc_pkg::CMD_DREG ||
                   cmd_req.code == omc_pkg::CMD_HALT);
    cmd_haltonly = cmd_req.valid && (cmd_req.code == omc_pkg::CMD_CPU_REG ||
                   cmd_req.code == omc_pkg::CMD_TRACE ||
                   cmd_req.code == omc_pkg::CMD_GO);
    halt_cmd     = cmd_req.valid && cmd_req.code == omc_pkg::CMD_HALT;
    bkpt_any     = ctrl_bkpt || trig_bkpt;
    running      = st.mode == omc_pkg::MODE_RUN || st.mode == omc_pkg::MODE_TRACE;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st              = st;
    next_st.rsp          = '0;
    next_st.vec_fetch    = 1'b0;
    next_st.halt_entry   = 1'b0;
    next_st.pin_comm     = st.mode != omc_pkg::MODE_RESET;
    // Bit timer free-runs only once the pin carries debug traffic
    if (next_st.pin_comm)
    begin
      next_st.tick_cnt = st.tick_cnt + 4'h1;
      next_st.bit_tick = st.tick_cnt == omc_pkg::BIT_LAST;
    end
    else
    begin
      next_st.tick_cnt = omc_pkg::BIT_CNT_ZERO;
      next_st.bit_tick = 1'b0;
    end

    unique case (st.mode)
      omc_pkg::MODE_RESET:
      begin
        next_st.vec_done = 1'b0;
        if (cmd_req.valid)
          next_st.rsp.reject = 1'b1;
        if (!sys_reset_act)
        begin
          // Pin only matters after power-on or forced reset
          if (reset_mode_sel && !pin_in)
          begin
            next_st.mode       = omc_pkg::MODE_HALT;
            next_st.halt_entry = 1'b1;
          end
          else
          begin
            next_st.mode      = omc_pkg::MODE_RUN;
            next_st.vec_fetch = 1'b1;
            next_st.vec_done  = 1'b1;
          end
        end
      end
      omc_pkg::MODE_RUN, omc_pkg::MODE_TRACE:
      begin
        next_st.rsp.accept = cmd_nonintr;
        next_st.rsp.reject = cmd_haltonly ||
                             (cmd_req.valid && cmd_req.code == omc_pkg::CMD_NONE);
        // All halt sources merge into one entry
        if (halt_cmd || halt_instr || bkpt_any ||
            (st.mode == omc_pkg::MODE_TRACE && instr_done))
        begin
          next_st.mode       = omc_pkg::MODE_HALT;
          next_st.halt_entry = 1'b1;
        end
        else if (st.mode == omc_pkg::MODE_RUN && wait_instr)
          next_st.mode = omc_pkg::MODE_WAIT;
        else if (st.mode == omc_pkg::MODE_RUN && stop_instr)
        begin
          next_st.mode         = omc_pkg::MODE_STOP;
          next_st.stop_partial = stop_partial_sel;
        end
      end
      omc_pkg::MODE_HALT:
      begin
        next_st.rsp.accept = cmd_nonintr || cmd_haltonly;
        next_st.rsp.reject = cmd_req.valid && cmd_req.code == omc_pkg::CMD_NONE;
        if (cmd_req.valid && cmd_req.code == omc_pkg::CMD_GO)
        begin
          next_st.mode = omc_pkg::MODE_RUN;
          // Halted straight from reset: vector not yet taken
          if (!st.vec_done)
          begin
            next_st.vec_fetch = 1'b1;
            next_st.vec_done  = 1'b1;
          end
        end
        else if (cmd_req.valid && cmd_req.code == omc_pkg::CMD_TRACE)
        begin
          next_st.mode = omc_pkg::MODE_TRACE;
          if (!st.vec_done)
          begin
            next_st.vec_fetch = 1'b1;
            next_st.vec_done  = 1'b1;
          end
        end
      end
      omc_pkg::MODE_WAIT, omc_pkg::MODE_STOP:
      begin
        // Memory cannot be reached while clocks are gated
        next_st.rsp.lp_error = cmd_req.valid &&
                               cmd_req.code == omc_pkg::CMD_MEM_STAT;
        next_st.rsp.accept   = st.mode == omc_pkg::MODE_WAIT && halt_cmd;
        next_st.rsp.reject   = cmd_req.valid && !next_st.rsp.lp_error &&
                               !next_st.rsp.accept;
        if (st.mode == omc_pkg::MODE_WAIT && halt_cmd)
        begin
          next_st.mode       = omc_pkg::MODE_HALT;
          next_st.halt_entry = 1'b1;
        end
        else if (wake_irq)
        begin
          next_st.mode         = omc_pkg::MODE_RUN;
          next_st.stop_partial = 1'b0;
        end
      end
      default:
        next_st.mode = omc_pkg::MODE_RESET;
    endcase

    // Device reset overrides every mode
    if (sys_reset_act)
    begin
      next_st.mode         = omc_pkg::MODE_RESET;
      next_st.stop_partial = 1'b0;
      next_st.halt_entry   = 1'b0;
      next_st.vec_fetch    = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st <= omc_pkg::STATE_RESET;
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs
  always_comb
  begin
    mode             = st.mode;
    cmd_rsp          = st.rsp;
    bit_tick         = st.bit_tick;
    vec_fetch        = st.vec_fetch;
    vec_addr         = omc_pkg::RESET_VECTOR;
    halt_entry       = st.halt_entry;
    pin_is_mode_sel  = !st.pin_comm;
    // Pin is input only while it selects the mode
    pin_oe           = st.pin_comm && tx_oe;
    pin_out          = st.pin_comm && tx_out;
    power.cpu_run    = running;
    power.cpu_clk    = st.mode != omc_pkg::MODE_WAIT &&
                       st.mode != omc_pkg::MODE_STOP;
    power.sys_clk    = st.mode != omc_pkg::MODE_STOP;
    power.core_power = !(st.mode == omc_pkg::MODE_STOP && st.stop_partial);
    power.ram_retain = st.mode == omc_pkg::MODE_STOP;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_rel_run;
    st.mode == omc_pkg::MODE_RESET && !sys_reset_act && (pin_in || !reset_mode_sel);
  endsequence
  sequence s_trace_start;
    st.mode == omc_pkg::MODE_HALT && cmd_req.valid && cmd_req.code == omc_pkg::CMD_TRACE
      && !sys_reset_act;
  endsequence
  sequence s_trace_end;
    st.mode == omc_pkg::MODE_TRACE && instr_done && !sys_reset_act;
  endsequence

  reset_run_a: assert property (s_rel_run |=> mode == omc_pkg::MODE_RUN)
    else $error("run not entered after reset");
  run_vector_a: assert property (s_rel_run |=> vec_fetch && vec_addr == omc_pkg::RESET_VECTOR)
    else $error("vector fetch missing");
  reset_halt_a: assert property (st.mode == omc_pkg::MODE_RESET && !sys_reset_act
      && reset_mode_sel && !pin_in |=> mode == omc_pkg::MODE_HALT && !power.cpu_run)
    else $error("halt not entered after reset");
  halt_cmd_a: assert property (st.mode == omc_pkg::MODE_RUN && halt_cmd && !sys_reset_act
      |=> mode == omc_pkg::MODE_HALT && cmd_rsp.accept)
    else $error("halt command ignored");
  halt_instr_a: assert property (running && halt_instr && !sys_reset_act
      |=> mode == omc_pkg::MODE_HALT)
    else $error("halt instruction ignored");
  bkpt_halt_a: assert property (running && (ctrl_bkpt || trig_bkpt) && !sys_reset_act
      |=> mode == omc_pkg::MODE_HALT)
    else $error("breakpoint ignored");
  halt_suspend_a: assert property (mode == omc_pkg::MODE_HALT |-> !power.cpu_run)
    else $error("cpu runs while halted");
  nonintr_ok_a: assert property ((running || st.mode == omc_pkg::MODE_HALT)
      && cmd_nonintr && !sys_reset_act |=> cmd_rsp.accept && !cmd_rsp.reject)
    else $error("non-intrusive command refused");
  haltonly_rej_a: assert property (running && cmd_haltonly && !sys_reset_act
      |=> cmd_rsp.reject && !cmd_rsp.accept)
    else $error("halt-only command taken while running");
  trace_one_a: assert property (s_trace_start |=> mode == omc_pkg::MODE_TRACE
      && power.cpu_run)
    else $error("trace did not start");
  trace_back_a: assert property (s_trace_end |=> mode == omc_pkg::MODE_HALT
      && halt_entry)
    else $error("trace did not halt again");
  wait_clk_a: assert property (mode == omc_pkg::MODE_WAIT
      |-> !power.cpu_clk && power.sys_clk)
    else $error("wait clock gating wrong");
  stop_clk_a: assert property (mode == omc_pkg::MODE_STOP
      |-> !power.cpu_clk && !power.sys_clk && power.ram_retain)
    else $error("stop clock gating wrong");
  stop_power_a: assert property (mode == omc_pkg::MODE_STOP
      |-> power.ram_retain && power.core_power == !st.stop_partial)
    else $error("stop power state wrong");
  go_run_a: assert property (st.mode == omc_pkg::MODE_HALT && cmd_req.valid
      && cmd_req.code == omc_pkg::CMD_GO && !sys_reset_act
      |=> mode == omc_pkg::MODE_RUN && power.cpu_run)
    else $error("go did not resume");
  pin_role_a: assert property (mode == omc_pkg::MODE_RESET |=> !pin_oe)
    else $error("pin driven during mode select");
  bit_time_a: assert property (bit_tick && mode != omc_pkg::MODE_RESET
      ##1 (mode != omc_pkg::MODE_RESET) [*8] ##1 (mode != omc_pkg::MODE_RESET) [*7]
      |=> bit_tick)
    else $error("bit time not sixteen");
  bit_gap_a: assert property (bit_tick |=> !bit_tick)
    else $error("bit ticks too close");
  wait_cmd_a: assert property (st.mode == omc_pkg::MODE_WAIT && cmd_req.valid
      && cmd_req.code == omc_pkg::CMD_MEM_STAT && !sys_reset_act
      |=> cmd_rsp.lp_error && !cmd_rsp.accept)
    else $error("status command in wait not flagged");
  wait_halt_a: assert property (st.mode == omc_pkg::MODE_WAIT && halt_cmd
      && !sys_reset_act |=> mode == omc_pkg::MODE_HALT)
    else $error("halt command did not wake wait");
  one_entry_a: assert property (halt_entry |=> !halt_entry)
    else $error("duplicate halt entry");

endmodule

`default_nettype wire

/* File: dv/omc_host.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Debug host on the shared pin
module omc_host (
  input  wire logic mclk,
  input  wire logic hold_low,
  input  wire logic dev_oe,
  input  wire logic dev_out,
  input  wire logic dev_tick,
  output logic      pin_level,
  output logic      slot_end
);
  logic [3:0] slot;

  // Pull-up on the pin, so a released line reads high rather than the last value
  assign pin_level = hold_low ? 1'b0 : (dev_oe ? dev_out : 1'b1);

  // Host aligns on each device tick and expects the next one 16 clocks later
  always_ff @(posedge mclk) slot <= dev_tick ? 4'h1 : slot + 4'h1;
  assign slot_end = slot == 4'h0;
endmodule

`default_nettype wire

/* File: dv/omc_mode_ctrl_test.sv */
`timescale 1ns/1ns
`default_nettype none

module omc_mode_ctrl_test;
  logic mclk = 0, rst_b = 0, sys_reset_act = 1, reset_mode_sel = 0, hold_low = 0;
  logic tx_out = 0, tx_oe = 0, halt_instr = 0, ctrl_bkpt = 0, trig_bkpt = 0;
  logic instr_done = 0, wait_instr = 0, stop_instr = 0, stop_partial_sel = 0, wake_irq = 0;
  logic pin_in, pin_out, pin_oe, pin_is_mode_sel, bit_tick, vec_fetch, halt_entry, slot_end;
  logic [15:0]           vec_addr;
  omc_pkg::omc_cmd_req_t cmd_req = '0;
  omc_pkg::omc_cmd_rsp_t cmd_rsp;
  omc_pkg::omc_mode_t    mode;
  omc_pkg::omc_power_t   power;
  logic [31:0]           seed = 32'hA48C;
  int                    fails = 0, total_checks = 0, cycles = 0;

  omc_mode_ctrl omc_mode_ctrl_i (.mclk(mclk), .rst_b(rst_b), .sys_reset_act(sys_reset_act),
    .reset_mode_sel(reset_mode_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_is_mode_sel(pin_is_mode_sel), .tx_out(tx_out), .tx_oe(tx_oe), .bit_tick(bit_tick),
    .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .halt_instr(halt_instr), .ctrl_bkpt(ctrl_bkpt),
    .trig_bkpt(trig_bkpt), .instr_done(instr_done), .wait_instr(wait_instr),
    .stop_instr(stop_instr), .stop_partial_sel(stop_partial_sel), .wake_irq(wake_irq),
    .vec_fetch(vec_fetch), .vec_addr(vec_addr), .halt_entry(halt_entry), .mode(mode),
    .power(power));

  omc_host omc_host_i (.mclk(mclk), .hold_low(hold_low), .dev_oe(pin_oe), .dev_out(pin_out),
    .dev_tick(bit_tick), .pin_level(pin_in), .slot_end(slot_end));

  always #4 mclk = ~mclk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Response as {accept, reject, lp_error}
  function automatic logic [2:0] exp_rsp(input omc_pkg::omc_mode_t m,
                                         input omc_pkg::omc_cmd_t c);
    if (c == omc_pkg::CMD_NONE || m == omc_pkg::MODE_RESET)
      return 3'h2;
    if (m == omc_pkg::MODE_WAIT || m == omc_pkg::MODE_STOP)
      return (c == omc_pkg::CMD_MEM_STAT) ? 3'h1 :
             (c == omc_pkg::CMD_HALT && m == omc_pkg::MODE_WAIT) ? 3'h4 : 3'h2;
    if (c inside {omc_pkg::CMD_CPU_REG, omc_pkg::CMD_TRACE, omc_pkg::CMD_GO})
      return (m == omc_pkg::MODE_HALT) ? 3'h4 : 3'h2;
    return 3'h4;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input omc_pkg::omc_cmd_t c);
    logic [31:0] r;
    logic [2:0]  e;
    // Idle edge first, so valid never rises in the step where it fell
    step();
    e = exp_rsp(mode, c);
    r = xs();
    cmd_req = '{valid: 1'b1, code: c};
    tx_oe = r[0];
    tx_out = r[1];
    step();
    cmd_req.valid = 1'b0;
    chk(cmd_rsp, e);
    if (mode != omc_pkg::MODE_RESET)
    begin
      chk(pin_oe, tx_oe);
      chk(pin_out, tx_out);
    end
  endtask

  // Mode-changing codes are left to their own scenarios
  task automatic sweep(input int n);
    omc_pkg::omc_cmd_t c;
    for (int i = 0; i < n; i++)
    begin
      c = omc_pkg::omc_cmd_t'(3'((n == 8) ? i : xs() % 8));
      if (!((c == omc_pkg::CMD_HALT && mode != omc_pkg::MODE_STOP) ||
            (c inside {omc_pkg::CMD_TRACE, omc_pkg::CMD_GO} && mode == omc_pkg::MODE_HALT)))
        cmd(c);
    end
  endtask

  task automatic do_reset(input logic pin_hi, input logic sel);
    logic run;
    run = pin_hi || !sel;
    rst_b = 0;
    sys_reset_act = 1;
    hold_low = !pin_hi;
    reset_mode_sel = sel;
    repeat (6) step();
    rst_b = 1;
    repeat (2) step();
    chk(mode, omc_pkg::MODE_RESET);
    chk(pin_is_mode_sel, 1'b1);
    chk(pin_oe, 1'b0);
    cmd(omc_pkg::CMD_MEM);
    sys_reset_act = 0;
    step();
    hold_low = 0;
    chk(mode, run ? omc_pkg::MODE_RUN : omc_pkg::MODE_HALT);
    chk(vec_fetch, run);
    chk(halt_entry, !run);
    chk(vec_addr, 16'hFFFE);
    // Pin role register follows the mode one clock later
    step();
    chk(pin_is_mode_sel, 1'b0);
  endtask

  task automatic halt_ev(input logic [2:0] e);
    {halt_instr, ctrl_bkpt, trig_bkpt} = e;
    step();
    {halt_instr, ctrl_bkpt, trig_bkpt} = 3'h0;
    chk(mode, omc_pkg::MODE_HALT);
    chk(halt_entry, 1'b1);
    chk(power.cpu_run, 1'b0);
    step();
    chk(halt_entry, 1'b0);
    cmd(omc_pkg::CMD_GO);
    chk(mode, omc_pkg::MODE_RUN);
  endtask

  task automatic tick_gap();
    int n;
    n = 0;
    while (bit_tick !== 1'b1 && n < 40)
    begin
      step();
      n++;
    end
    n = 0;
    do
    begin
      step();
      n++;
    end while (bit_tick !== 1'b1 && n < 40);
    chk(n, 16);
    chk(slot_end, 1'b1);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Hang guard, far beyond the few hundred cycles needed
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    do_reset(1'b1, 1'b1);
    tick_gap();
    sweep(8);
    for (int i = 1; i < 8; i++) halt_ev(3'(i));
    cmd(omc_pkg::CMD_HALT);
    chk(mode, omc_pkg::MODE_HALT);
    chk(halt_entry, 1'b1);
    sweep(8);
    cmd(omc_pkg::CMD_TRACE);
    chk(mode, omc_pkg::MODE_TRACE);
    chk(power.cpu_run, 1'b1);
    repeat (3) step();
    chk(mode, omc_pkg::MODE_TRACE);
    instr_done = 1;
    step();
    instr_done = 0;
    chk(mode, omc_pkg::MODE_HALT);
    chk(halt_entry, 1'b1);
    cmd(omc_pkg::CMD_GO);
    wait_instr = 1;
    step();
    wait_instr = 0;
    chk(mode, omc_pkg::MODE_WAIT);
    chk(power.cpu_clk, 1'b0);
    chk(power.sys_clk, 1'b1);
    sweep(8);
    cmd(omc_pkg::CMD_HALT);
    chk(mode, omc_pkg::MODE_HALT);
    cmd(omc_pkg::CMD_GO);
    for (int p = 0; p < 2; p++)
    begin
      stop_partial_sel = p[0];
      stop_instr = 1;
      step();
      stop_instr = 0;
      chk(mode, omc_pkg::MODE_STOP);
      chk(power.sys_clk, 1'b0);
      chk(power.cpu_clk, 1'b0);
      chk(power.core_power, !p[0]);
      if (p == 1) chk(power.ram_retain, 1'b1);
      sweep(8);
      wake_irq = 1;
      step();
      wake_irq = 0;
      chk(mode, omc_pkg::MODE_RUN);
    end
    do_reset(1'b0, 1'b1);
    sweep(30);
    cmd(omc_pkg::CMD_GO);
    chk(mode, omc_pkg::MODE_RUN);
    chk(vec_fetch, 1'b1);
    sweep(30);
    do_reset(1'b0, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
